// ---- verilog/par_out_regs.svh ----
// Constants for the parallel output ports
`ifndef PAR_OUT_REGS_SVH
`define PAR_OUT_REGS_SVH
`define CLK_PERIOD_NS  10
`define PCLK_PERIOD_NS 120
`define PCLK_HALF_CYC  ((`PCLK_PERIOD_NS / `CLK_PERIOD_NS) / 2)
`define DIV_W          4
`define PORT_COUNT     3
`define FIFO_DEPTH     8
`define DATA_W         16
`define CHAN_W         3
`endif

// ---- verilog/par_out_pkg.sv ----
// Types shared by the parallel output ports
`include "par_out_regs.svh"
package par_out_pkg;
  typedef struct packed {
    logic                  gain;
    logic                  inphase;
    logic [`CHAN_W-1:0]    chan;
    logic [`DATA_W-1:0]    data;
  } out_word_t;
endpackage

// ---- verilog/word_fifo_if.sv ----
// Valid/ready carrier between a port and its word FIFO
`timescale 1ns/10ps
`default_nettype none
interface word_fifo_if #(parameter int W = 21) ();
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user  (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// ---- verilog/word_fifo.sv ----
// Word FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int W     = 21,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic    core_clk,
  input  wire logic    rst_n,
  // Both sides
  word_fifo_if.store   fq
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          wr_ready;
  } fifo_state_t;

  fifo_state_t  s_q;
  fifo_state_t  s_d;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  assign push        = fq.wr_valid && s_q.wr_ready;
  assign pop         = fq.rd_valid && fq.rd_ready;
  assign fq.wr_ready = s_q.wr_ready;
  assign fq.rd_valid = (s_q.cnt != '0);
  assign fq.rd_data  = mem[s_q.rp];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + AW'(1);
    end
    s_d.cnt      = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Ready is registered so the top sees it straight from a flop
    s_d.wr_ready = (s_d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{wp: '0, rp: '0, cnt: '0, wr_ready: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; empty count hides stale words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[s_q.wp] <= fq.wr_data;
    end
  end
endmodule // word_fifo
`default_nettype wire

// ---- verilog/par_out_ports.sv ----
// Three parallel output ports with request/acknowledge and shared port clock
// Overview of operation
// - Master mode drives the port clock; slave mode takes it from the receiver.
// - Each port presents its word on its own 16-bit data bus.
// - Each port drives a 3-bit channel index with every word.
// - In-phase flag high for I data, low for Q data.
// - Gain-word flag high when the bus carries a gain word.
// - Each port drives its own active-high request.
// - Active-low master reset holds all port logic in reset.
`timescale 1ns/10ps
`default_nettype none
`include "par_out_regs.svh"
module par_out_ports (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Port clock pin and mode strap
  input  wire logic                 master_mode,
  input  wire logic                 pclk_in,
  output logic                      pclk_out,
  output logic                      pclk_oe_n,
  // Core side, port A
  input  wire logic                 a_word_valid,
  input  wire logic [`DATA_W-1:0]   a_word_data,
  input  wire logic [`CHAN_W-1:0]   a_word_chan,
  input  wire logic                 a_word_inphase,
  input  wire logic                 a_word_gain,
  output logic                      a_word_ready,
  // Core side, port B
  input  wire logic                 b_word_valid,
  input  wire logic [`DATA_W-1:0]   b_word_data,
  input  wire logic [`CHAN_W-1:0]   b_word_chan,
  input  wire logic                 b_word_inphase,
  input  wire logic                 b_word_gain,
  output logic                      b_word_ready,
  // Core side, port C
  input  wire logic                 c_word_valid,
  input  wire logic [`DATA_W-1:0]   c_word_data,
  input  wire logic [`CHAN_W-1:0]   c_word_chan,
  input  wire logic                 c_word_inphase,
  input  wire logic                 c_word_gain,
  output logic                      c_word_ready,
  // Output port A
  output logic [`DATA_W-1:0]        out_a_data_bus,
  output logic [`CHAN_W-1:0]        out_a_channel_index,
  output logic                      out_a_inphase_flag,
  output logic                      out_a_gainword_flag,
  output logic                      out_a_request,
  input  wire logic                 out_a_acknowledge,
  // Output port B
  output logic [`DATA_W-1:0]        out_b_data_bus,
  output logic [`CHAN_W-1:0]        out_b_channel_index,
  output logic                      out_b_inphase_flag,
  output logic                      out_b_gainword_flag,
  output logic                      out_b_request,
  input  wire logic                 out_b_acknowledge,
  // Output port C
  output logic [`DATA_W-1:0]        out_c_data_bus,
  output logic [`CHAN_W-1:0]        out_c_channel_index,
  output logic                      out_c_inphase_flag,
  output logic                      out_c_gainword_flag,
  output logic                      out_c_request,
  input  wire logic                 out_c_acknowledge
);
  localparam int NP = `PORT_COUNT;
  localparam int WW = $bits(par_out_pkg::out_word_t);
  localparam logic [`DIV_W-1:0] HALF_M1 = `DIV_W'(`PCLK_HALF_CYC - 1);

  typedef struct packed {
    logic [1:0]                       mode_sync;
    logic [1:0]                       pclk_sync;
    logic                             pclk_prev;
    logic [`DIV_W-1:0]                div_cnt;
    logic                             pclk_drv;
    logic                             oe_n;
    logic [NP-1:0][1:0]               ack_sync;
    logic [NP-1:0]                    req;
    par_out_pkg::out_word_t [NP-1:0]  word;
  } state_t;

  state_t                  r_q;
  state_t                  r_d;
  logic                    master;
  logic                    tick;
  logic [NP-1:0]           ack_raw;
  logic [NP-1:0]           in_valid;
  logic [NP-1:0]           in_ready;
  par_out_pkg::out_word_t  in_word [NP];
  logic [NP-1:0]           fifo_valid;
  logic [NP-1:0]           fifo_pop;
  par_out_pkg::out_word_t  fifo_word [NP];

  assign ack_raw    = {out_c_acknowledge, out_b_acknowledge, out_a_acknowledge};
  assign in_valid   = {c_word_valid, b_word_valid, a_word_valid};
  assign in_word[0] = '{gain: a_word_gain, inphase: a_word_inphase, chan: a_word_chan,
                        data: a_word_data};
  assign in_word[1] = '{gain: b_word_gain, inphase: b_word_inphase, chan: b_word_chan,
                        data: b_word_data};
  assign in_word[2] = '{gain: c_word_gain, inphase: c_word_inphase, chan: c_word_chan,
                        data: c_word_data};
  assign a_word_ready = in_ready[0];
  assign b_word_ready = in_ready[1];
  assign c_word_ready = in_ready[2];

  // Each port buffers its words so a slow receiver stalls the core side
  for (genvar i = 0; i < NP; i++) begin : g_port
    word_fifo_if #(.W(WW)) fq ();
    assign fq.wr_valid   = in_valid[i];
    assign fq.wr_data    = in_word[i];
    assign in_ready[i]   = fq.wr_ready;
    assign fifo_valid[i] = fq.rd_valid;
    assign fifo_word[i]  = fq.rd_data;
    assign fq.rd_ready   = fifo_pop[i];
    word_fifo #(.W(WW), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .fq       (fq)
    );
  end

  assign master = r_q.mode_sync[1];
  // Master acts in the cycle after its own rise, so the receiver never sees
  // the word move at the edge it samples on; slave acts on the detected edge
  assign tick = master ? ((r_q.div_cnt == '0) && r_q.pclk_drv)
                       : (r_q.pclk_sync[1] && !r_q.pclk_prev);

  always_comb begin
    r_d = r_q;
    r_d.mode_sync = {r_q.mode_sync[0], master_mode};
    r_d.pclk_sync = {r_q.pclk_sync[0], pclk_in};
    r_d.pclk_prev = r_q.pclk_sync[1];
    r_d.oe_n      = !master;
    if (master) begin
      if (r_q.div_cnt == HALF_M1) begin
        r_d.div_cnt  = '0;
        r_d.pclk_drv = !r_q.pclk_drv;
      end else begin
        r_d.div_cnt = r_q.div_cnt + `DIV_W'(1);
      end
    end else begin
      // Slave mode leaves the pin undriven and parks the divider
      r_d.div_cnt  = '0;
      r_d.pclk_drv = 1'b0;
    end
    for (int i = 0; i < NP; i++) begin
      r_d.ack_sync[i] = {r_q.ack_sync[i][0], ack_raw[i]};
      fifo_pop[i] = 1'b0;
      if (tick) begin
        if (!r_q.req[i] || r_q.ack_sync[i][1]) begin
          fifo_pop[i] = fifo_valid[i];
          r_d.req[i]  = fifo_valid[i];
          if (fifo_valid[i]) begin
            r_d.word[i] = fifo_word[i];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{oe_n: 1'b1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign pclk_out            = r_q.pclk_drv;
  assign pclk_oe_n           = r_q.oe_n;
  assign out_a_data_bus      = r_q.word[0].data;
  assign out_a_channel_index = r_q.word[0].chan;
  assign out_a_inphase_flag  = r_q.word[0].inphase;
  assign out_a_gainword_flag = r_q.word[0].gain;
  assign out_a_request       = r_q.req[0];
  assign out_b_data_bus      = r_q.word[1].data;
  assign out_b_channel_index = r_q.word[1].chan;
  assign out_b_inphase_flag  = r_q.word[1].inphase;
  assign out_b_gainword_flag = r_q.word[1].gain;
  assign out_b_request       = r_q.req[1];
  assign out_c_data_bus      = r_q.word[2].data;
  assign out_c_channel_index = r_q.word[2].chan;
  assign out_c_inphase_flag  = r_q.word[2].inphase;
  assign out_c_gainword_flag = r_q.word[2].gain;
  assign out_c_request       = r_q.req[2];
endmodule // par_out_ports
`default_nettype wire

// ---- test/par_out_ports_properties.sv ----
// Checker of port clock, port A hand-over and reset
`timescale 1ns/10ps
`default_nettype none
`include "par_out_regs.svh"
module par_out_ports_properties (
  // Clock, reset, mode
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               master_mode,
  // Port clock pin
  input wire logic               pclk_out,
  input wire logic               pclk_oe_n,
  // Port A
  input wire logic [`DATA_W-1:0] out_a_data_bus,
  input wire logic [`CHAN_W-1:0] out_a_channel_index,
  input wire logic               out_a_inphase_flag,
  input wire logic               out_a_gainword_flag,
  input wire logic               out_a_request,
  input wire logic               out_a_acknowledge
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Six quiet cycles cannot reach a tick through the ack sync
  sequence wait6;
    (out_a_request && !out_a_acknowledge) [*6];
  endsequence
  AST_CLK_DRIVE: assert property (master_mode [*6] |-> !pclk_oe_n)
    else $error("clock not driven");
  AST_CLK_FREE: assert property (!master_mode [*6] |-> pclk_oe_n && !pclk_out)
    else $error("clock not released");
  AST_CLK_HIGH: assert property ($rose(pclk_out) |=> pclk_out [*5] ##1 !pclk_out)
    else $error("clock high time");
  AST_A_DATA: assert property (wait6 |=> out_a_request && $stable(out_a_data_bus))
    else $error("data moved early");
  AST_A_CHAN: assert property (wait6 |=> $stable(out_a_channel_index))
    else $error("channel moved early");
  AST_A_FLAGS: assert property (
    wait6 |=> $stable({out_a_inphase_flag, out_a_gainword_flag}))
    else $error("flags moved early");
  AST_A_TICK: assert property (
    !pclk_oe_n && $rose(out_a_request) |-> $past(pclk_out) && !$past(pclk_out, 2))
    else $error("request off tick");
  AST_RESET: assert property (disable iff (1'b0) !rst_n |-> pclk_oe_n && !out_a_request)
    else $error("port active in reset");
  cover property (out_a_request && out_a_acknowledge);
  cover property (wait6);
  cover property ($rose(pclk_out));
endmodule // par_out_ports_properties
bind par_out_ports par_out_ports_properties u_props (.core_clk, .rst_n, .master_mode,
  .pclk_out, .pclk_oe_n, .out_a_data_bus, .out_a_channel_index, .out_a_inphase_flag,
  .out_a_gainword_flag, .out_a_request, .out_a_acknowledge);
`default_nettype wire

// ---- test/rx_model.sv ----
// Receiver model: slave port clock and acknowledges
`timescale 1ns/10ps
`default_nettype none
module rx_model (
  // Control
  input  wire logic  run_clk,
  input  wire logic  slow,
  input  wire logic  hold,
  // Pins
  input  wire logic  pclk_pin,
  output logic       pclk_drv = 1'b0,
  output logic [2:0] ack = 3'h0
);
  logic [7:0] lfsr_q = 8'hA5;
  // Runs only while the receiver owns the pin, else stands low
  always #62.5 pclk_drv <= run_clk & ~pclk_drv;
  // Ack moves at the fall so both sides see one level at the rise
  always @(negedge pclk_pin) begin
    lfsr_q <= {lfsr_q[6:0], ^(lfsr_q & 8'hB8)};
    ack <= hold ? 3'h0 : (slow ? lfsr_q[2:0] : 3'h7);
  end
endmodule // rx_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the parallel output ports
`timescale 1ns/10ps
`default_nettype none
`include "par_out_regs.svh"
module tb_top;
  logic core_clk = 1'b0;
  // Starts high so the first reset is a real falling edge at time zero
  logic rst_n = 1'b1;
  logic mode = 1'b1;
  logic slow = 1'b0;
  logic hold = 1'b0;
  logic go = 1'b0;
  logic full = 1'b0;
  logic [31:0] seed = 32'h12DF;
  logic [2:0] vld = 3'h0;
  wire [2:0] rdy, req, ack;
  wire pclk_out, pclk_oe_n, pclk_drv;
  wire pin = pclk_oe_n ? pclk_drv : pclk_out;
  par_out_pkg::out_word_t w [3] = '{default: '0};
  wire par_out_pkg::out_word_t o [3];
  par_out_pkg::out_word_t q [3][$];
  int err_count = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  par_out_ports u_dut (.core_clk, .rst_n, .master_mode(mode), .pclk_in(pin), .pclk_out,
    .pclk_oe_n, .a_word_valid(vld[0]), .a_word_data(w[0].data), .a_word_chan(w[0].chan),
    .a_word_inphase(w[0].inphase), .a_word_gain(w[0].gain), .a_word_ready(rdy[0]),
    .b_word_valid(vld[1]), .b_word_data(w[1].data), .b_word_chan(w[1].chan),
    .b_word_inphase(w[1].inphase), .b_word_gain(w[1].gain), .b_word_ready(rdy[1]),
    .c_word_valid(vld[2]), .c_word_data(w[2].data), .c_word_chan(w[2].chan),
    .c_word_inphase(w[2].inphase), .c_word_gain(w[2].gain), .c_word_ready(rdy[2]),
    .out_a_data_bus(o[0].data), .out_a_channel_index(o[0].chan),
    .out_a_inphase_flag(o[0].inphase), .out_a_gainword_flag(o[0].gain),
    .out_a_request(req[0]), .out_a_acknowledge(ack[0]),
    .out_b_data_bus(o[1].data), .out_b_channel_index(o[1].chan),
    .out_b_inphase_flag(o[1].inphase), .out_b_gainword_flag(o[1].gain),
    .out_b_request(req[1]), .out_b_acknowledge(ack[1]),
    .out_c_data_bus(o[2].data), .out_c_channel_index(o[2].chan),
    .out_c_inphase_flag(o[2].inphase), .out_c_gainword_flag(o[2].gain),
    .out_c_request(req[2]), .out_c_acknowledge(ack[2]));
  rx_model u_rx (.run_clk(~mode), .slow, .hold, .pclk_pin(pin), .pclk_drv, .ack);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Refused words are held, as the core side must do
  always @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_n && vld[i] && rdy[i]) q[i].push_back(w[i]);
      if (!go) vld[i] <= 1'b0;
      else if (!(vld[i] && !rdy[i])) begin
        seed = xs(seed);
        vld[i] <= seed[0] | full;
        w[i] <= seed[31:11];
      end
    end
  end
  // The receiver takes a word at a clock rise with request and ack high
  always @(posedge pin) begin
    for (int i = 0; i < 3; i++) begin
      if (req[i] && ack[i]) chk(o[i], q[i].size() ? q[i].pop_front() : 21'h0);
    end
  end
  task automatic drain();
    int n;
    go <= 1'b0;
    full <= 1'b0;
    for (n = 0; n < 3000 && (q[0].size() + q[1].size() + q[2].size() || req); n++) begin
      @(posedge core_clk);
    end
    chk(req, 3'h0);
    chk(q[0].size() + q[1].size() + q[2].size(), 0);
    if (n >= 3000) summarize();
  endtask
  task automatic run(input logic m, input logic s, input int n);
    rst_n <= 1'b0;
    mode <= m;
    slow <= s;
    repeat (16) @(posedge core_clk);
    for (int i = 0; i < 3; i++) q[i].delete();
    chk({pclk_oe_n, rdy, req}, 7'h78);
    rst_n <= 1'b1;
    go <= 1'b1;
    repeat (n) @(posedge core_clk);
    drain();
    $display("run mode=%0d slow=%0d errors=%0d", m, s, err_count);
  endtask
  initial begin
    int n;
    run(1'b1, 1'b0, 400);
    run(1'b1, 1'b1, 400);
    hold <= 1'b1;
    full <= 1'b1;
    go <= 1'b1;
    for (n = 0; n < 60 && rdy !== 3'h0; n++) @(posedge core_clk);
    // Let the held acknowledge settle: each port then holds one word and a full FIFO
    repeat (30) @(posedge core_clk);
    chk(rdy, 3'h0);
    for (int i = 0; i < 3; i++) chk(q[i].size(), 32'(`FIFO_DEPTH + 1));
    hold <= 1'b0;
    drain();
    $display("fill done errors=%0d", err_count);
    run(1'b0, 1'b1, 400);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
